// >>> rtl/cbrf_core_regs.sv
// Banked general and special register set of a 16-bit core.
// Assumes one core clock; the sequencer and ALU drive their ports
// synchronously and an APB master reaches the same registers.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
`include "cbrf_defines.svh"

module cbrf_core_regs
    import cbrf_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Sequencer read ports
    input wire cbrf_reg_id_t [1:0] i_rd_sel,
    output logic [1:0][31:0] o_rd_data,
    // Sequencer write port and ALU flags
    input wire cbrf_wr_t i_wr,
    input wire cbrf_alu_t i_alu,
    // Direct views for fetch and vectoring
    output logic [`CBRF_LONG_W-1:0] o_pc,
    output logic [`CBRF_LONG_W-1:0] o_vector_table_base,
    output logic [`CBRF_FLG_W-1:0] o_flags,
    // APB slave
    input wire cbrf_apb_req_t i_apb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr
);

    // ****************************************
    // Read decode
    // ****************************************
    function automatic logic [31:0] read_reg(cbrf_state_t s, cbrf_reg_id_t id);
        cbrf_bank_t b;
        logic [31:0] v;
        b = s.bank[s.cpu_state_word[`CBRF_FLG_B]];
        v = 32'h0000_0000;
        unique case (id)
            CBRF_DATA_WORD_ZERO: v = {16'h0000, b.dw[0]};
            CBRF_DATA_WORD_ONE: v = {16'h0000, b.dw[1]};
            CBRF_DATA_WORD_TWO: v = {16'h0000, b.dw[2]};
            CBRF_DATA_WORD_THREE: v = {16'h0000, b.dw[3]};
            CBRF_ADDR_WORD_ZERO: v = {16'h0000, b.aw[0]};
            CBRF_ADDR_WORD_ONE: v = {16'h0000, b.aw[1]};
            CBRF_FRAME_BASE_PTR: v = {16'h0000, b.fb};
            CBRF_VECTOR_TABLE_BASE: v = {12'h000, s.vector_table_base};
            CBRF_NEXT_INSTR_COUNTER: v = {12'h000, s.pc};
            CBRF_USER_STACK_PTR: v = {16'h0000, s.user_stack_ptr};
            CBRF_IRQ_STACK_PTR: v = {16'h0000, s.irq_stack_ptr};
            CBRF_STATIC_BASE_PTR: v = {16'h0000, s.sb};
            CBRF_CPU_STATE_WORD: v = {21'h000000, s.cpu_state_word};
            CBRF_DATA_ZERO_UPPER_BYTE: v = {24'h000000, b.dw[0][15:8]};
            CBRF_DATA_ZERO_LOWER_BYTE: v = {24'h000000, b.dw[0][7:0]};
            CBRF_DATA_ONE_UPPER_BYTE: v = {24'h000000, b.dw[1][15:8]};
            CBRF_DATA_ONE_LOWER_BYTE: v = {24'h000000, b.dw[1][7:0]};
            CBRF_DATA_PAIR_LOW: v = {b.dw[2], b.dw[0]};
            CBRF_DATA_PAIR_HIGH: v = {b.dw[3], b.dw[1]};
            CBRF_ADDR_PAIR: v = {b.aw[1], b.aw[0]};
            CBRF_ACTIVE_STACK_PTR:
            begin
                v = {16'h0000, s.cpu_state_word[`CBRF_FLG_U] ? s.irq_stack_ptr : s.user_stack_ptr};
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_reg

    // ****************************************
    // Write decode
    // ****************************************
    // Only the active bank is touched, so a bank switch never
    // disturbs the parked copy.
    function automatic cbrf_state_t write_reg(cbrf_state_t s, cbrf_reg_id_t id,
                                              logic [31:0] v);
        cbrf_bank_t b;
        logic bi;
        bi = s.cpu_state_word[`CBRF_FLG_B];
        b = s.bank[bi];
        unique case (id)
            CBRF_DATA_WORD_ZERO: b.dw[0] = v[15:0];
            CBRF_DATA_WORD_ONE: b.dw[1] = v[15:0];
            CBRF_DATA_WORD_TWO: b.dw[2] = v[15:0];
            CBRF_DATA_WORD_THREE: b.dw[3] = v[15:0];
            CBRF_ADDR_WORD_ZERO: b.aw[0] = v[15:0];
            CBRF_ADDR_WORD_ONE: b.aw[1] = v[15:0];
            CBRF_FRAME_BASE_PTR: b.fb = v[15:0];
            CBRF_VECTOR_TABLE_BASE: s.vector_table_base = v[19:0];
            CBRF_NEXT_INSTR_COUNTER: s.pc = v[19:0];
            CBRF_USER_STACK_PTR: s.user_stack_ptr = v[15:0];
            CBRF_IRQ_STACK_PTR: s.irq_stack_ptr = v[15:0];
            CBRF_STATIC_BASE_PTR: s.sb = v[15:0];
            CBRF_CPU_STATE_WORD: s.cpu_state_word = v[10:0];
            CBRF_DATA_ZERO_UPPER_BYTE: b.dw[0][15:8] = v[7:0];
            CBRF_DATA_ZERO_LOWER_BYTE: b.dw[0][7:0] = v[7:0];
            CBRF_DATA_ONE_UPPER_BYTE: b.dw[1][15:8] = v[7:0];
            CBRF_DATA_ONE_LOWER_BYTE: b.dw[1][7:0] = v[7:0];
            CBRF_DATA_PAIR_LOW:
            begin
                b.dw[2] = v[31:16];
                b.dw[0] = v[15:0];
            end
            CBRF_DATA_PAIR_HIGH:
            begin
                b.dw[3] = v[31:16];
                b.dw[1] = v[15:0];
            end
            CBRF_ADDR_PAIR:
            begin
                b.aw[1] = v[31:16];
                b.aw[0] = v[15:0];
            end
            CBRF_ACTIVE_STACK_PTR:
            begin
                if (s.cpu_state_word[`CBRF_FLG_U])
                begin
                    s.irq_stack_ptr = v[15:0];
                end
                else
                begin
                    s.user_stack_ptr = v[15:0];
                end
            end
            default:
            begin
                b = s.bank[bi];
            end
        endcase
        s.bank[bi] = b;
        return s;
    endfunction : write_reg

    // ****************************************
    // Result width helpers for the flags
    // ****************************************
    function automatic logic result_zero(logic [31:0] r, cbrf_size_t z);
        logic zf;
        unique case (z)
            CBRF_SIZE_BYTE: zf = (r[7:0] == 8'h00);
            CBRF_SIZE_WORD: zf = (r[15:0] == 16'h0000);
            default: zf = (r == 32'h0000_0000);
        endcase
        return zf;
    endfunction : result_zero

    function automatic logic result_sign(logic [31:0] r, cbrf_size_t z);
        logic sf;
        unique case (z)
            CBRF_SIZE_BYTE: sf = r[7];
            CBRF_SIZE_WORD: sf = r[15];
            default: sf = r[31];
        endcase
        return sf;
    endfunction : result_sign

    // ****************************************
    // State update
    // ****************************************
    cbrf_state_t st_r;
    cbrf_state_t st_nxt;
    logic apb_hit;
    logic apb_first;
    logic apb_wr_done;
    cbrf_reg_id_t apb_id;

    assign apb_hit = (i_apb.paddr <= `CBRF_APB_LAST) && (i_apb.paddr[1:0] == 2'h0);
    assign apb_id = cbrf_reg_id_t'(i_apb.paddr[6:2]);
    assign apb_first = i_apb.psel && i_apb.penable && !st_r.pready;
    assign apb_wr_done = i_apb.psel && i_apb.penable && st_r.pready && i_apb.pwrite
                         && apb_hit;

    always_comb
    begin
        st_nxt = st_r;
        // ALU results land first; an explicit flag-word write
        // in the same cycle overrides them.
        if (i_alu.upd_c)
        begin
            st_nxt.cpu_state_word[`CBRF_FLG_C] = i_alu.c;
        end
        if (i_alu.upd_zs)
        begin
            st_nxt.cpu_state_word[`CBRF_FLG_Z] = result_zero(i_alu.res, i_alu.size);
            st_nxt.cpu_state_word[`CBRF_FLG_S] = result_sign(i_alu.res, i_alu.size);
        end
        if (i_alu.upd_o)
        begin
            st_nxt.cpu_state_word[`CBRF_FLG_O] = i_alu.o;
        end
        // One wait cycle, then a one-cycle ready
        st_nxt.pready = apb_first;
        st_nxt.pslverr = apb_first && !apb_hit;
        st_nxt.prdata = 32'h0000_0000;
        if (apb_first && apb_hit && !i_apb.pwrite)
        begin
            st_nxt.prdata = read_reg(st_r, apb_id);
        end
        if (apb_wr_done)
        begin
            st_nxt = write_reg(st_nxt, apb_id, i_apb.pwdata);
        end
        // The sequencer owns the core, so its write lands last
        if (i_wr.en)
        begin
            st_nxt = write_reg(st_nxt, i_wr.sel, i_wr.data);
        end
        for (int p = 0; p < 2; p++)
        begin
            st_nxt.rd[p] = read_reg(st_r, i_rd_sel[p]);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_r <= '0;
            st_r.cpu_state_word <= `CBRF_FLG_RST;
            st_r.pc <= `CBRF_LONG_RST;
            st_r.user_stack_ptr <= `CBRF_WORD_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_rd_data = st_r.rd;
    assign o_pc = st_r.pc;
    assign o_vector_table_base = st_r.vector_table_base;
    assign o_flags = st_r.cpu_state_word;
    assign o_pready = st_r.pready;
    assign o_prdata = st_r.prdata;
    assign o_pslverr = st_r.pslverr;

    // ****************************************
    // Checks
    // ****************************************
    logic flg_wr_now;
    assign flg_wr_now = (i_wr.en && i_wr.sel == CBRF_CPU_STATE_WORD)
                        || (apb_wr_done && apb_id == CBRF_CPU_STATE_WORD);

    chk_parked_bank: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        1'b1 |=> st_r.bank[!$past(st_r.cpu_state_word[`CBRF_FLG_B])]
                 == $past(st_r.bank[!st_r.cpu_state_word[`CBRF_FLG_B]]))
        else $error("parked bank changed");

    chk_zero_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_alu.upd_zs && !flg_wr_now)
        |=> o_flags[`CBRF_FLG_Z]
            == (($past(i_alu.size) == CBRF_SIZE_BYTE) ? ($past(i_alu.res[7:0]) == 8'h00)
                : ($past(i_alu.size) == CBRF_SIZE_WORD) ? ($past(i_alu.res[15:0]) == 16'h0000)
                : ($past(i_alu.res) == 32'h0000_0000)))
        else $error("zero flag wrong");

    chk_sign_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_alu.upd_zs && !flg_wr_now)
        |=> o_flags[`CBRF_FLG_S]
            == (($past(i_alu.size) == CBRF_SIZE_BYTE) ? $past(i_alu.res[7])
                : ($past(i_alu.size) == CBRF_SIZE_WORD) ? $past(i_alu.res[15])
                : $past(i_alu.res[31])))
        else $error("sign flag wrong");

    chk_carry_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_alu.upd_c && !flg_wr_now) |=> o_flags[`CBRF_FLG_C] == $past(i_alu.c))
        else $error("carry flag wrong");

    chk_ovf_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_alu.upd_o && !flg_wr_now) |=> o_flags[`CBRF_FLG_O] == $past(i_alu.o))
        else $error("overflow flag wrong");

    chk_stack_select: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_rd_sel[0] == CBRF_ACTIVE_STACK_PTR && st_r.cpu_state_word[`CBRF_FLG_U])
        |=> o_rd_data[0][15:0] == $past(st_r.irq_stack_ptr))
        else $error("active stack pointer wrong");

    chk_pair_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_rd_sel[1] == CBRF_DATA_PAIR_LOW
        |=> o_rd_data[1] == {$past(st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[2]),
                             $past(st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[0])})
        else $error("data pair read wrong");

    chk_byte_write: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr.en && i_wr.sel == CBRF_DATA_ZERO_UPPER_BYTE && !flg_wr_now
         && !apb_wr_done)
        |=> st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[0][15:8] == $past(i_wr.data[7:0])
            && st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[0][7:0]
               == $past(st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[0][7:0]))
        else $error("byte write wrong");

    // ****************************************
    // Register bus, view and read port checks
    // ****************************************
    // The bus always answers after one wait state; a master that
    // waits for ready instead of counting stays correct if this grows.
    chk_apb_wait: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        apb_first |=> o_pready)
        else $error("bus answer late");

    chk_pready_pulse: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_pready |=> !o_pready)
        else $error("bus ready held");

    chk_apb_refuse: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (apb_first && !apb_hit) |=> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("bus refusal wrong");

    chk_flag_write: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (apb_wr_done && apb_id == CBRF_CPU_STATE_WORD && !i_wr.en)
        |=> o_flags == $past(i_apb.pwdata[10:0]))
        else $error("flag word write wrong");

    chk_pc_write: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (apb_wr_done && apb_id == CBRF_NEXT_INSTR_COUNTER && !i_wr.en)
        |=> o_pc == $past(i_apb.pwdata[19:0]))
        else $error("instruction counter write wrong");

    chk_vector_table_base_write: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (apb_wr_done && apb_id == CBRF_VECTOR_TABLE_BASE && !i_wr.en)
        |=> o_vector_table_base == $past(i_apb.pwdata[19:0]))
        else $error("vector table base write wrong");

    chk_word_write: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (apb_wr_done && apb_id == CBRF_DATA_WORD_THREE && !i_wr.en)
        |=> st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[3] == $past(i_apb.pwdata[15:0]))
        else $error("data word write wrong");

    chk_usp_select: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_rd_sel[0] == CBRF_ACTIVE_STACK_PTR && !st_r.cpu_state_word[`CBRF_FLG_U])
        |=> o_rd_data[0][15:0] == $past(st_r.user_stack_ptr))
        else $error("user stack pointer not selected");

    chk_pair_high: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_rd_sel[0] == CBRF_DATA_PAIR_HIGH
        |=> o_rd_data[0] == {$past(st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[3]),
                             $past(st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].dw[1])})
        else $error("upper data pair read wrong");

    chk_addr_pair: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_rd_sel[0] == CBRF_ADDR_PAIR
        |=> o_rd_data[0] == {$past(st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].aw[1]),
                             $past(st_r.bank[st_r.cpu_state_word[`CBRF_FLG_B]].aw[0])})
        else $error("address pair read wrong");

    cov_bank_switch: cover property (
        @(posedge i_sys_clk) disable iff (!i_rst_n) $changed(st_r.cpu_state_word[`CBRF_FLG_B]));
    cov_stack_switch: cover property (
        @(posedge i_sys_clk) disable iff (!i_rst_n) $changed(st_r.cpu_state_word[`CBRF_FLG_U]));
    cov_apb_write: cover property (
        @(posedge i_sys_clk) disable iff (!i_rst_n) apb_wr_done);
    cov_apb_error: cover property (
        @(posedge i_sys_clk) disable iff (!i_rst_n) apb_first && !apb_hit);
    cov_pair_read: cover property (
        @(posedge i_sys_clk) disable iff (!i_rst_n) i_rd_sel[1] == CBRF_DATA_PAIR_LOW);

endmodule : cbrf_core_regs

// >>> rtl/cbrf_defines.svh
// Constants of the banked core register file: flag positions,
// widths, reset values and the register bus map.
// Assumes inclusion by the package, the design and the bench; guarded.
`ifndef CBRF_DEFINES_SVH
`define CBRF_DEFINES_SVH

// ****************************************
// Flag word layout
// ****************************************
`define CBRF_FLG_W 11
`define CBRF_FLG_C 0
`define CBRF_FLG_D 1
`define CBRF_FLG_Z 2
`define CBRF_FLG_S 3
`define CBRF_FLG_B 4
`define CBRF_FLG_O 5
`define CBRF_FLG_I 6
`define CBRF_FLG_U 7

// ****************************************
// Widths and reset values
// ****************************************
`define CBRF_WORD_W 16
`define CBRF_LONG_W 20
`define CBRF_FLG_RST 11'h000
`define CBRF_WORD_RST 16'h0000
`define CBRF_LONG_RST 20'h00000

// ****************************************
// Register bus map: register id times four
// ****************************************
`define CBRF_APB_LAST 8'h30

`endif

// >>> rtl/cbrf_pkg.sv
// Types of the banked core register file.
// Assumes the defines header is on the include path.
`include "cbrf_defines.svh"

package cbrf_pkg;

    // ****************************************
    // Register selectors
    // ****************************************
    typedef enum logic [4:0] {
        CBRF_DATA_WORD_ZERO = 5'h00,
        CBRF_DATA_WORD_ONE = 5'h01,
        CBRF_DATA_WORD_TWO = 5'h02,
        CBRF_DATA_WORD_THREE = 5'h03,
        CBRF_ADDR_WORD_ZERO = 5'h04,
        CBRF_ADDR_WORD_ONE = 5'h05,
        CBRF_FRAME_BASE_PTR = 5'h06,
        CBRF_VECTOR_TABLE_BASE = 5'h07,
        CBRF_NEXT_INSTR_COUNTER = 5'h08,
        CBRF_USER_STACK_PTR = 5'h09,
        CBRF_IRQ_STACK_PTR = 5'h0A,
        CBRF_STATIC_BASE_PTR = 5'h0B,
        CBRF_CPU_STATE_WORD = 5'h0C,
        CBRF_DATA_ZERO_UPPER_BYTE = 5'h0D,
        CBRF_DATA_ZERO_LOWER_BYTE = 5'h0E,
        CBRF_DATA_ONE_UPPER_BYTE = 5'h0F,
        CBRF_DATA_ONE_LOWER_BYTE = 5'h10,
        CBRF_DATA_PAIR_LOW = 5'h11,
        CBRF_DATA_PAIR_HIGH = 5'h12,
        CBRF_ADDR_PAIR = 5'h13,
        CBRF_ACTIVE_STACK_PTR = 5'h14
    } cbrf_reg_id_t;

    typedef enum logic [1:0] {
        CBRF_SIZE_BYTE = 2'h0,
        CBRF_SIZE_WORD = 2'h1,
        CBRF_SIZE_LONG = 2'h2
    } cbrf_size_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [3:0][`CBRF_WORD_W-1:0] dw;
        logic [1:0][`CBRF_WORD_W-1:0] aw;
        logic [`CBRF_WORD_W-1:0] fb;
    } cbrf_bank_t;

    typedef struct packed {
        logic en;
        cbrf_reg_id_t sel;
        logic [31:0] data;
    } cbrf_wr_t;

    typedef struct packed {
        logic upd_c;
        logic c;
        logic upd_zs;
        logic upd_o;
        logic o;
        cbrf_size_t size;
        logic [31:0] res;
    } cbrf_alu_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cbrf_apb_req_t;

    typedef struct packed {
        cbrf_bank_t [1:0] bank;
        logic [`CBRF_LONG_W-1:0] vector_table_base;
        logic [`CBRF_LONG_W-1:0] pc;
        logic [`CBRF_WORD_W-1:0] user_stack_ptr;
        logic [`CBRF_WORD_W-1:0] irq_stack_ptr;
        logic [`CBRF_WORD_W-1:0] sb;
        logic [`CBRF_FLG_W-1:0] cpu_state_word;
        logic [1:0][31:0] rd;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cbrf_state_t;

endpackage : cbrf_pkg

// >>> tb/cbrf_seq_model.sv
// Partner model of the core's sequencer and arithmetic unit.
// Assumes one core clock; drives the write, flag and read-select ports.
`timescale 1ns/100ps
module cbrf_seq_model
    import cbrf_pkg::*;
(
    // Clock
    input wire logic i_sys_clk,
    // Core ports
    output cbrf_reg_id_t [1:0] o_rd_sel,
    output cbrf_wr_t o_wr,
    output cbrf_alu_t o_alu,
    input wire logic [1:0][31:0] i_rd_data
);
    initial
    begin
        o_rd_sel = '{CBRF_NEXT_INSTR_COUNTER, CBRF_DATA_WORD_ZERO};
        o_wr = '0;
        o_alu = '0;
    end

    // ****************************************
    // Sequencer actions
    // ****************************************
    // Idle data is inverted so a stale value never looks valid
    task automatic core_wr(input cbrf_reg_id_t sel, input logic [31:0] d);
        @(posedge i_sys_clk);
        o_wr <= '{1'b1, sel, d};
        @(posedge i_sys_clk);
        o_wr <= '{1'b0, sel, ~d};
    endtask : core_wr

    // Flag updates never carry the debug bit, which stays cleared
    task automatic alu_op(input logic c, input logic o, input cbrf_size_t sz,
        input logic [31:0] r);
        @(posedge i_sys_clk);
        o_alu <= '{1'b1, c, 1'b1, 1'b1, o, sz, r};
        @(posedge i_sys_clk);
        o_alu <= '{1'b0, ~c, 1'b0, 1'b0, ~o, sz, ~r};
    endtask : alu_op

    // Data shows one cycle after the selector is taken
    task automatic rd_port(input cbrf_reg_id_t sel, output logic [31:0] q,
        output logic [31:0] q1);
        @(posedge i_sys_clk);
        o_rd_sel <= '{sel, sel};
        @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        q = i_rd_data[0];
        q1 = i_rd_data[1];
    endtask : rd_port
endmodule : cbrf_seq_model

// >>> tb/cpu_banked_register_file_tb.sv
// Self-checking bench of the banked core register file.
// Assumes the partner model drives the core ports; APB is driven here.
`timescale 1ns/100ps
`include "cbrf_defines.svh"
module cpu_banked_register_file_tb
    import cbrf_pkg::*;
;
    logic i_sys_clk;
    logic i_rst_n;
    cbrf_reg_id_t [1:0] rd_sel;
    cbrf_wr_t wr;
    cbrf_alu_t alu;
    cbrf_apb_req_t apb;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0][31:0] rd_data;
    logic [19:0] pc;
    logic [19:0] vector_table_base;
    logic [10:0] flags;
    int bad_count;
    int n_tests;
    int unsigned seed;

    cbrf_core_regs i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_rd_sel(rd_sel),
        .o_rd_data(rd_data), .i_wr(wr), .i_alu(alu), .o_pc(pc), .o_vector_table_base(vector_table_base),
        .o_flags(flags), .i_apb(apb), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr));
    cbrf_seq_model i_seq (.i_sys_clk(i_sys_clk), .o_rd_sel(rd_sel), .o_wr(wr),
        .o_alu(alu), .i_rd_data(rd_data));

    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // ****************************************
    // Shared tasks and expectations
    // ****************************************
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Master never assumes the wait length; the bound only cuts a hang
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int n;
        @(posedge i_sys_clk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_sys_clk);
        apb.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        apb <= '{1'b0, 1'b0, w, ~a, ~d};
        if (pready !== 1'b1)
        begin
            chk("pready timeout", 32'h1, 32'h0);
            results();
        end
    endtask : apb_xfer

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb_xfer(1'b1, a, d, q, e);
    endtask : apb_wr

    task automatic apb_rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb_xfer(1'b0, a, 32'h0, q, e);
    endtask : apb_rd

    function automatic logic [31:0] width_mask(input int idx);
        if (idx == 7 || idx == 8)
            return 32'h000FFFFF;
        if (idx == 12)
            return 32'h000007FF;
        return 32'h0000FFFF;
    endfunction : width_mask

    // Zero and sign are judged on the operand size only
    function automatic logic [31:0] alu_flags(input logic c, input logic o,
        input cbrf_size_t sz, input logic [31:0] r);
        logic [31:0] m;
        logic [31:0] f;
        m = (sz == CBRF_SIZE_BYTE) ? 32'h000000FF :
            (sz == CBRF_SIZE_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
        f = 32'h0;
        f[`CBRF_FLG_C] = c;
        f[`CBRF_FLG_Z] = ((r & m) == 32'h0);
        f[`CBRF_FLG_S] = |(r & (m ^ (m >> 1)));
        f[`CBRF_FLG_O] = o;
        return f;
    endfunction : alu_flags

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [31:0] q;
        logic [31:0] v;
        logic [31:0] w;
        logic e;
        logic c;
        logic o;
        logic [31:0] q1;
        cbrf_reg_id_t ps[3];
        logic [7:0] hi_a[3];
        logic [7:0] lo_a[3];
        logic [31:0] corner[6];
        ps = '{CBRF_DATA_PAIR_LOW, CBRF_DATA_PAIR_HIGH, CBRF_ADDR_PAIR};
        hi_a = '{8'h08, 8'h0C, 8'h14};
        lo_a = '{8'h00, 8'h04, 8'h10};
        corner = '{32'h0, 32'h80, 32'h8000, 32'hFFFFFF00, 32'hFFFF0000, 32'h80000000};
        i_rst_n = 1'b0;
        apb = '0;
        bad_count = 0;
        n_tests = 0;
        seed = $urandom(65);
        repeat (10) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            apb_rd(8'(i * 4), q);
            chk($sformatf("reset reg %0d", i), 32'h0, q);
        end
        for (int i = 0; i < 13; i++)
        begin
            v = $urandom();
            if (i == 12)
                v[`CBRF_FLG_D] = 1'b0;
            apb_wr(8'(i * 4), v);
            apb_rd(8'(i * 4), q);
            chk($sformatf("reg %0d", i), v & width_mask(i), q);
            if (i == 7)
                chk("vector_table_base pin", v & 32'h000FFFFF, {12'h0, vector_table_base});
            if (i == 8)
                chk("pc pin", v & 32'h000FFFFF, {12'h0, pc});
        end
        apb_wr(8'h30, 32'h0);
        v = $urandom();
        w = $urandom();
        apb_wr(8'h00, v);
        apb_wr(8'h30, 32'(1) << `CBRF_FLG_B);
        apb_wr(8'h00, w);
        apb_rd(8'h00, q);
        chk("bank one word", {16'h0, w[15:0]}, q);
        apb_wr(8'h30, 32'h0);
        apb_rd(8'h00, q);
        chk("bank zero kept", {16'h0, v[15:0]}, q);
        apb_wr(8'h30, 32'(1) << `CBRF_FLG_B);
        apb_rd(8'h00, q);
        chk("bank one kept", {16'h0, w[15:0]}, q);
        apb_wr(8'h30, 32'h0);
        i_seq.core_wr(CBRF_DATA_ZERO_UPPER_BYTE, {v[31:8], w[15:8]});
        i_seq.core_wr(CBRF_DATA_ZERO_LOWER_BYTE, {v[31:8], w[7:0]});
        i_seq.core_wr(CBRF_DATA_ONE_UPPER_BYTE, {w[31:8], v[15:8]});
        i_seq.core_wr(CBRF_DATA_ONE_LOWER_BYTE, {w[31:8], v[7:0]});
        apb_rd(8'h00, q);
        chk("bytes of word zero", {16'h0, w[15:0]}, q);
        apb_rd(8'h04, q);
        chk("bytes of word one", {16'h0, v[15:0]}, q);
        for (int i = 0; i < 3; i++)
        begin
            v = $urandom();
            i_seq.core_wr(ps[i], v);
            apb_rd(hi_a[i], q);
            chk("pair upper", {16'h0, v[31:16]}, q);
            apb_rd(lo_a[i], q);
            chk("pair lower", {16'h0, v[15:0]}, q);
            i_seq.rd_port(ps[i], q, q1);
            chk("pair port", v, q);
            chk("pair port one", v, q1);
        end
        v = $urandom();
        w = $urandom();
        apb_wr(8'h24, v);
        apb_wr(8'h28, w);
        i_seq.rd_port(CBRF_ACTIVE_STACK_PTR, q, q1);
        chk("user stack", {16'h0, v[15:0]}, q);
        chk("user stack port one", {16'h0, v[15:0]}, q1);
        apb_wr(8'h30, 32'(1) << `CBRF_FLG_U);
        i_seq.rd_port(CBRF_ACTIVE_STACK_PTR, q, q1);
        chk("irq stack", {16'h0, w[15:0]}, q);
        chk("irq stack port one", {16'h0, w[15:0]}, q1);
        apb_wr(8'h30, 32'h0);
        for (int i = 0; i < 24; i++)
        begin
            v = (i < 6) ? corner[i] : $urandom();
            c = 1'($urandom_range(1));
            o = 1'($urandom_range(1));
            i_seq.alu_op(c, o, cbrf_size_t'(i % 3), v);
            #1;
            chk("alu flags", alu_flags(c, o, cbrf_size_t'(i % 3), v), {21'h0, flags});
        end
        apb_xfer(1'b0, 8'h34, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        apb_wr(8'h00, 32'h0000A5C3);
        apb_xfer(1'b1, 8'h01, 32'h00001111, q, e);
        chk("misaligned error", 32'h1, {31'h0, e});
        apb_rd(8'h00, q);
        chk("misaligned ignored", 32'h0000A5C3, q);
        results();
    end
endmodule : cpu_banked_register_file_tb
